// File: src/tape_record_write_read_sequencer.sv
/*
  write and read record sequencer between a tape controller and a tape drive,
  with its mode bits and status reached over an ahb-lite slave.
  assumes all controller and drive pins are asynchronous to clk_i, and the
  drive write clock is much slower (about 160 ns period) than clk_i.
*/
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module tape_record_write_read_sequencer
  import tape_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic drive_write_clock_i,
  input wire logic drive_read_strobe_i,
  input wire logic [8:0] drive_read_data_i,
  input wire logic ctl_data_request_i,
  input wire logic [7:0] ctl_write_data_i,
  output logic [7:0] drive_write_data_o,
  output logic drive_write_parity_o,
  output logic force_channel3_one_o,
  output logic force_parity_one_o,
  output logic drive_write_pulse_o,
  output logic drive_lrc_request_o,
  output logic ctl_write_ack_o,
  output logic [8:0] ctl_read_data_o,
  output logic ctl_read_ack_o,
  output logic ctl_crc_error_o,
  output logic ctl_lrc_error_o,
  output logic ctl_vparity_error_o,
  output logic tapemark_found_o,
  output logic crc_slot_flag_o,
  output logic lrc_slot_flag_o
);

  // ****************************************************************
  // pin synchronisers and edge enables
  // ****************************************************************
  logic [19:0] pin_meta_r;
  logic [19:0] pin_sync_r;
  logic wclk_prev_r;
  logic rstb_prev_r;
  logic wclk_s;
  logic rstb_s;
  logic data_req_s;
  logic [7:0] wdata_s;
  logic [8:0] rdata_s;
  logic wclk_rise;
  logic composite_read_tick;

  // two flops per pin; only the second stage is ever looked at
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta_r <= 20'h00000;
      pin_sync_r <= 20'h00000;
    end
    else
    begin
      pin_meta_r <= {drive_write_clock_i, drive_read_strobe_i, ctl_data_request_i,
                     ctl_write_data_i, drive_read_data_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {wclk_s, rstb_s, data_req_s, wdata_s, rdata_s} = pin_sync_r;

  // edge history for the two drive strobes
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wclk_prev_r <= 1'b0;
      rstb_prev_r <= 1'b0;
    end
    else
    begin
      wclk_prev_r <= wclk_s;
      rstb_prev_r <= rstb_s;
    end
  end

  assign wclk_rise = wclk_s & ~wclk_prev_r;
  assign composite_read_tick = rstb_s & ~rstb_prev_r;

  // ****************************************************************
  // ahb-lite slave: control, status and check readback
  // ****************************************************************
  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic launch_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] status_word;
  logic addr_phase;
  char_check_if wr_chk();
  char_check_if rd_chk();

  assign addr_phase = hsel_i & htrans_i[1] & hready_i;

  // mode bits written in the data phase; launch bit is a one-cycle pulse
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      ctrl_r <= CTRL_RESET;
      launch_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= addr_phase & hwrite_i;
      wr_addr_r <= haddr_i[7:0];
      launch_r <= 1'b0;
      if (wr_pend_r && wr_addr_r == CTRL_ADDR)
      begin
        ctrl_r <= hwdata_i[CTRL_WIDTH-1:0];
        launch_r <= hwdata_i[CTRL_LAUNCH];
      end
    end
  end

  // read data sampled at the address phase so it stands in the data phase
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_r <= 32'h00000000;
    else if (addr_phase && !hwrite_i)
    begin
      case (haddr_i[7:0])
        CTRL_ADDR: rdata_r <= {26'h0000000, ctrl_r};
        STATUS_ADDR: rdata_r <= status_word;
        CHECK_ADDR: rdata_r <= {14'h0000, wr_chk.crc, rd_chk.lrc};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  // zero wait states, never an error answer
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  assign hrdata_o = rdata_r;

  logic write_cmd_enable;
  logic even_parity_select;
  logic seven_track_mode;
  logic tapemark_write_select;
  logic forward_motion;
  logic read_path_enabled;
  assign write_cmd_enable = ctrl_r[CTRL_WRITE_CMD];
  assign even_parity_select = ctrl_r[CTRL_EVEN_PAR];
  assign seven_track_mode = ctrl_r[CTRL_SEVEN];
  assign tapemark_write_select = ctrl_r[CTRL_TAPEMARK];
  assign forward_motion = ctrl_r[CTRL_FORWARD];
  assign read_path_enabled = ctrl_r[CTRL_READ_PATH];

  // ****************************************************************
  // write sequence
  // ****************************************************************
  char_check u_write_check (.clk_i(clk_i), .reset_i(reset_i), .chk(wr_chk));

  logic write_active_r;
  logic [3:0] eor_cnt_r;
  logic char_write_tick;
  logic check_char_slot;
  logic crc_slot_w;
  logic lrc_slot_w;
  logic [7:0] wr_char;
  logic [7:0] mark_gates;
  logic zero_even;

  // counter 8 bit gates write clocks into character ticks
  assign char_write_tick = wclk_rise & eor_cnt_r[3];
  // file marks skip the crc slot; seven-track preset makes 3 act as 7
  assign crc_slot_w = ~write_active_r & eor_cnt_r[3] & (eor_cnt_r[2:0] == EOR_CRC_COUNT)
                      & ~tapemark_write_select & ~seven_track_mode;
  assign lrc_slot_w = ~write_active_r & eor_cnt_r[3]
                      & (eor_cnt_r[2:0] == EOR_LRC_COUNT);
  assign check_char_slot = crc_slot_w | lrc_slot_w;

  // file mark: all ones through the mode's output gates
  assign mark_gates = seven_track_mode ? MARK_GATES_SEVEN : MARK_GATES_NINE;
  assign wr_char = tapemark_write_select ? mark_gates : wdata_s;
  assign zero_even = even_parity_select & (wr_char == 8'h00);

  // write_active and the end-of-record counter
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      write_active_r <= 1'b0;
      eor_cnt_r <= 4'h0;
    end
    else if (launch_r)
    begin
      if (write_cmd_enable)
      begin
        write_active_r <= 1'b1;
        eor_cnt_r <= seven_track_mode ? EOR_PRESET_SEVEN : EOR_PRESET_NINE;
      end
    end
    else if (char_write_tick)
    begin
      if (write_active_r)
      begin
        // request low: this tick carries the last character
        if (!data_req_s)
          write_active_r <= 1'b0;
      end
      else if (lrc_slot_w)
        eor_cnt_r <= 4'h0;
      else
        eor_cnt_r <= eor_cnt_r + 4'h1;
    end
  end

  // output latch: data, crc, or zeros while the drive makes the lrc
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      drive_write_data_o <= 8'h00;
      drive_write_parity_o <= 1'b0;
      force_channel3_one_o <= 1'b0;
      force_parity_one_o <= 1'b0;
      drive_lrc_request_o <= 1'b0;
    end
    else if (launch_r)
    begin
      drive_write_data_o <= 8'h00;
      drive_write_parity_o <= 1'b0;
      force_channel3_one_o <= 1'b0;
      force_parity_one_o <= 1'b0;
      drive_lrc_request_o <= 1'b0;
    end
    else if (char_write_tick && write_active_r)
    begin
      // zero even character would leave a blank the read side cannot see
      drive_write_data_o <= wr_char | {5'h00, zero_even, 2'h0};
      drive_write_parity_o <= char_parity(wr_char, even_parity_select) | zero_even;
      force_channel3_one_o <= zero_even;
      force_parity_one_o <= zero_even;
    end
    else if (char_write_tick && crc_slot_w)
    begin
      drive_write_data_o <= wr_chk.crc[7:0];
      drive_write_parity_o <= char_parity(wr_chk.crc[7:0], even_parity_select);
      force_channel3_one_o <= 1'b0;
      force_parity_one_o <= 1'b0;
    end
    else if (char_write_tick && lrc_slot_w)
      drive_lrc_request_o <= 1'b0;
    else if (lrc_slot_w && !drive_lrc_request_o)
    begin
      drive_lrc_request_o <= 1'b1;
      drive_write_data_o <= 8'h00;
      drive_write_parity_o <= 1'b0;
      force_channel3_one_o <= 1'b0;
      force_parity_one_o <= 1'b0;
    end
  end

  // record pulses to the drive, acks to the controller (none for marks)
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      drive_write_pulse_o <= 1'b0;
      ctl_write_ack_o <= 1'b0;
    end
    else
    begin
      drive_write_pulse_o <= char_write_tick & (write_active_r | check_char_slot);
      ctl_write_ack_o <= char_write_tick & write_active_r
                         & ~tapemark_write_select;
    end
  end

  // crc generator takes each body character as it is latched
  assign wr_chk.tick = char_write_tick & write_active_r;
  assign wr_chk.clear = launch_r;
  assign wr_chk.data = {char_parity(wr_char, even_parity_select) | zero_even,
                        wr_char | {5'h00, zero_even, 2'h0}};

  // ****************************************************************
  // read sequence
  // ****************************************************************
  char_check u_read_check (.clk_i(clk_i), .reset_i(reset_i), .chk(rd_chk));

  logic [8:0] rd_latch_r;
  logic checker_clock_pulse_r;
  logic crc_slot_r;
  logic lrc_slot_r;
  logic eor_done_r;
  logic [1:0] rd_gap_r;
  logic [1:0] strobe_cnt_r;
  logic [3:0] gap_cnt_r;
  logic tm_char_flag_r;
  logic more_than_two_chars;
  logic tapemark_detected;
  logic record_in_progress;
  logic tapemark_char_detect;
  logic chk_crc_r;
  logic chk_lrc_r;

  assign more_than_two_chars = (strobe_cnt_r == STROBES_MORE);
  assign tapemark_detected = tapemark_found_o;
  assign record_in_progress = more_than_two_chars | tapemark_detected;
  assign tapemark_char_detect = (rdata_s[7:0] == mark_gates);

  // read latch and its one-shot toward controller and checkers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_latch_r <= 9'h000;
      checker_clock_pulse_r <= 1'b0;
      ctl_read_ack_o <= 1'b0;
    end
    else
    begin
      if (composite_read_tick)
        rd_latch_r <= rdata_s;
      checker_clock_pulse_r <= composite_read_tick;
      ctl_read_ack_o <= composite_read_tick;
    end
  end

  // controller sees the character, or the lrc when the path is off
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctl_read_data_o <= 9'h000;
    else
      ctl_read_data_o <= read_path_enabled ? rd_latch_r : rd_chk.lrc;
  end

  assign rd_chk.tick = checker_clock_pulse_r;
  assign rd_chk.clear = launch_r;
  assign rd_chk.data = rd_latch_r;

  // check slots: three quiet write clocks end the body; not while writing
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_gap_r <= 2'h0;
      crc_slot_r <= 1'b0;
      lrc_slot_r <= 1'b0;
      eor_done_r <= 1'b0;
    end
    else if (launch_r)
    begin
      rd_gap_r <= 2'h0;
      crc_slot_r <= 1'b0;
      lrc_slot_r <= 1'b0;
      eor_done_r <= 1'b0;
    end
    else if (checker_clock_pulse_r && crc_slot_r)
    begin
      crc_slot_r <= 1'b0;
      lrc_slot_r <= 1'b1;
    end
    else if (checker_clock_pulse_r && lrc_slot_r)
    begin
      lrc_slot_r <= 1'b0;
      eor_done_r <= 1'b1;
    end
    else if (composite_read_tick)
      rd_gap_r <= 2'h0;
    else if (wclk_rise && record_in_progress && !write_active_r && !eor_done_r
             && !crc_slot_r && !lrc_slot_r)
    begin
      if (rd_gap_r == READ_GAP_END - 2'h1)
      begin
        rd_gap_r <= 2'h0;
        if (seven_track_mode || tapemark_detected)
          lrc_slot_r <= 1'b1;
        else
          crc_slot_r <= 1'b1;
      end
      else
        rd_gap_r <= rd_gap_r + 2'h1;
    end
  end

  // crc and lrc checks one cycle after the check character has been folded in; parity checked on each body character
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      chk_crc_r <= 1'b0;
      chk_lrc_r <= 1'b0;
      ctl_crc_error_o <= 1'b0;
      ctl_lrc_error_o <= 1'b0;
      ctl_vparity_error_o <= 1'b0;
    end
    else if (launch_r)
    begin
      chk_crc_r <= 1'b0;
      chk_lrc_r <= 1'b0;
      ctl_crc_error_o <= 1'b0;
      ctl_lrc_error_o <= 1'b0;
      ctl_vparity_error_o <= 1'b0;
    end
    else
    begin
      chk_crc_r <= checker_clock_pulse_r & crc_slot_r;
      chk_lrc_r <= checker_clock_pulse_r & lrc_slot_r;
      if (chk_crc_r && forward_motion && rd_chk.crc != 9'h000)
        ctl_crc_error_o <= 1'b1;
      if (chk_lrc_r && forward_motion && rd_chk.lrc != 9'h000)
        ctl_lrc_error_o <= 1'b1;
      if (checker_clock_pulse_r && !crc_slot_r && !lrc_slot_r
          && rd_latch_r[8] != char_parity(rd_latch_r[7:0], even_parity_select))
        ctl_vparity_error_o <= 1'b1;
    end
  end

  // file mark detection: two mark characters then eight blanks
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tm_char_flag_r <= 1'b0;
      strobe_cnt_r <= 2'h0;
      gap_cnt_r <= 4'h0;
      tapemark_found_o <= 1'b0;
    end
    else if (launch_r)
    begin
      tm_char_flag_r <= 1'b1;
      strobe_cnt_r <= 2'h0;
      gap_cnt_r <= 4'h0;
      tapemark_found_o <= 1'b0;
    end
    else if (composite_read_tick)
    begin
      // the and with itself keeps a cleared flag cleared
      tm_char_flag_r <= tm_char_flag_r & tapemark_char_detect;
      gap_cnt_r <= 4'h0;
      if (strobe_cnt_r != STROBES_MORE)
        strobe_cnt_r <= strobe_cnt_r + 2'h1;
      if (strobe_cnt_r == STROBES_TWO)
        tm_char_flag_r <= 1'b0;
    end
    else if (wclk_rise && strobe_cnt_r == STROBES_TWO && gap_cnt_r != GAP_BLANKS)
    begin
      gap_cnt_r <= gap_cnt_r + 4'h1;
      if (gap_cnt_r == GAP_BLANKS - 4'h1 && tm_char_flag_r)
        tapemark_found_o <= 1'b1;
    end
  end

  assign crc_slot_flag_o = crc_slot_r;
  assign lrc_slot_flag_o = lrc_slot_r;

  // status word for software
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[ST_WRITE_ACTIVE] = write_active_r;
    status_word[ST_CRC_ERR] = ctl_crc_error_o;
    status_word[ST_LRC_ERR] = ctl_lrc_error_o;
    status_word[ST_VPAR_ERR] = ctl_vparity_error_o;
    status_word[ST_TAPEMARK] = tapemark_found_o;
    status_word[ST_MORE_TWO] = more_than_two_chars;
    status_word[ST_RECORD] = record_in_progress;
    status_word[ST_CRC_SLOT] = crc_slot_r;
    status_word[ST_LRC_SLOT] = lrc_slot_r;
  end

endmodule

// File: src/tape_seq_pkg.sv
/*
  shared constants for the tape record sequencer: register map, control and
  status bit positions, counter presets, check polynomial and parity helper.
  assumes it is compiled before every other file of the block.
*/
package tape_seq_pkg;

  // ****************************************************************
  // register map (byte addresses on the word-wide bus)
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CHECK_ADDR = 8'h08;

  // control register fields
  localparam int CTRL_WRITE_CMD = 0;
  localparam int CTRL_EVEN_PAR = 1;
  localparam int CTRL_SEVEN = 2;
  localparam int CTRL_TAPEMARK = 3;
  localparam int CTRL_FORWARD = 4;
  localparam int CTRL_READ_PATH = 5;
  localparam int CTRL_LAUNCH = 8;
  localparam int CTRL_WIDTH = 6;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;

  // status register fields
  localparam int ST_WRITE_ACTIVE = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_LRC_ERR = 2;
  localparam int ST_VPAR_ERR = 3;
  localparam int ST_TAPEMARK = 4;
  localparam int ST_MORE_TWO = 5;
  localparam int ST_RECORD = 6;
  localparam int ST_CRC_SLOT = 7;
  localparam int ST_LRC_SLOT = 8;

  // ****************************************************************
  // end-of-record counter and file mark figures
  // ****************************************************************
  localparam logic [3:0] EOR_PRESET_NINE = 4'h8;
  localparam logic [3:0] EOR_PRESET_SEVEN = 4'hc;
  localparam logic [2:0] EOR_CRC_COUNT = 3'h3;
  localparam logic [2:0] EOR_LRC_COUNT = 3'h7;
  localparam logic [7:0] MARK_GATES_NINE = 8'h13;
  localparam logic [7:0] MARK_GATES_SEVEN = 8'h0f;
  localparam logic [3:0] GAP_BLANKS = 4'h8;
  localparam logic [1:0] READ_GAP_END = 2'h3;
  localparam logic [1:0] STROBES_TWO = 2'h2;
  localparam logic [1:0] STROBES_MORE = 2'h3;
  localparam logic [8:0] CRC_POLY = 9'h1b1;

  // vertical parity bit for a character: even or odd count of ones
  function automatic logic char_parity(input logic [7:0] ch, input logic even_sel);
    char_parity = (^ch) ^ ~even_sel;
  endfunction

endpackage

// File: src/char_check_if.sv
/*
  carrier between the sequencer and one character check generator.
  assumes tick and clear are single-cycle strobes on the sequencer clock.
*/
`timescale 1ns/10ps
interface char_check_if;
  logic tick;
  logic clear;
  logic [8:0] data;
  logic [8:0] crc;
  logic [8:0] lrc;

  modport gen
  (
    input tick,
    input clear,
    input data,
    output crc,
    output lrc
  );

  modport user
  (
    output tick,
    output clear,
    output data,
    input crc,
    input lrc
  );
endinterface

// File: src/char_check.sv
/*
  cyclic and longitudinal check accumulators over a stream of characters.
  assumes the user clears it at the start of each operation.
*/
`timescale 1ns/10ps
module char_check
  import tape_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  char_check_if.gen chk
);

  // ****************************************************************
  // accumulators
  // ****************************************************************
  logic [8:0] crc_r;
  logic [8:0] lrc_r;
  logic [8:0] crc_nxt;

  // shift with feedback, then fold in the character
  always_comb
  begin
    crc_nxt = {crc_r[7:0], 1'b0} ^ (crc_r[8] ? CRC_POLY : 9'h000) ^ chk.data;
  end

  // cyclic check accumulator; clear beats a tick of the same cycle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      crc_r <= 9'h000;
    else if (chk.clear)
      crc_r <= 9'h000;
    else if (chk.tick)
      crc_r <= crc_nxt;
  end

  // longitudinal check is a plain running xor per channel
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      lrc_r <= 9'h000;
    else if (chk.clear)
      lrc_r <= 9'h000;
    else if (chk.tick)
      lrc_r <= lrc_r ^ chk.data;
  end

  assign chk.crc = crc_r;
  assign chk.lrc = lrc_r;

endmodule

// File: verification/tape_seq_properties.sv
/* port checker for the tape record sequencer.
   assumes the bind below attaches it to the top module. */
`timescale 1ns/10ps
module tape_seq_properties
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic drive_read_strobe_i,
  input wire logic [7:0] drive_write_data_o,
  input wire logic force_channel3_one_o,
  input wire logic force_parity_one_o,
  input wire logic drive_write_pulse_o,
  input wire logic drive_lrc_request_o,
  input wire logic ctl_write_ack_o,
  input wire logic ctl_read_ack_o
);
  // ****************
  // read and write handshakes
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // strobe pin edge, then ack after the sync stages
  sequence strobe_seen; $rose(drive_read_strobe_i); endsequence
  sequence ack_seen; ##[1:4] ctl_read_ack_o; endsequence
  read_ack_due_a: assert property (strobe_seen |-> ack_seen)
    else $error("read ack missing");
  read_ack_single_a: assert property (ctl_read_ack_o |=> !ctl_read_ack_o)
    else $error("read ack too long");
  write_ack_pulse_a: assert property (ctl_write_ack_o |-> drive_write_pulse_o ##1 !ctl_write_ack_o)
    else $error("write ack without record pulse");
  rec_single_a: assert property (drive_write_pulse_o |=> !drive_write_pulse_o)
    else $error("record pulse too long");
  zero_force_a: assert property (force_channel3_one_o |-> force_parity_one_o && drive_write_data_o == 8'h04)
    else $error("zero char forcing wrong");
  lrc_no_ack_a: assert property (drive_lrc_request_o |-> !ctl_write_ack_o)
    else $error("ack during check char");
  lrc_end_a: assert property ($fell(drive_lrc_request_o) |-> drive_write_pulse_o || $past(drive_write_pulse_o))
    else $error("lrc request ended without pulse");
  lrc_clear_a: assert property ($rose(drive_lrc_request_o) |-> (drive_write_data_o & 8'hfb) == 8'h00)
    else $error("latch not cleared for lrc");
endmodule
bind tape_record_write_read_sequencer tape_seq_properties u_tape_seq_properties
(
  .clk_i, .reset_i, .drive_read_strobe_i, .drive_write_data_o, .force_channel3_one_o,
  .force_parity_one_o, .drive_write_pulse_o, .drive_lrc_request_o, .ctl_write_ack_o,
  .ctl_read_ack_o
);

// File: verification/tape_drive_model.sv
/* tape drive stand-in: write clock and read characters.
   assumes the bench raises run_i only during an operation. */
`timescale 1ns/10ps
module tape_drive_model
(
  input wire logic run_i,
  output logic wclk_o = 1'b0,
  output logic strobe_o = 1'b0,
  output logic [8:0] rdata_o = 9'h000
);
  // ****************
  // link timing
  // ****************
  // 160 ns write clock, parked low between operations
  always #80 wclk_o = run_i & ~wclk_o;
  // one character: lines settle, strobe, then lines let go
  task automatic send(input logic [8:0] d);
    rdata_o = d;
    #33 strobe_o = 1'b1;
    #64 strobe_o = 1'b0;
    #20 rdata_o = ~d; // released lines must not keep the char
    #50;
  endtask
endmodule

// File: verification/tape_record_write_read_sequencer_tb_top.sv
/* self-checking bench for the tape record sequencer.
   assumes the drive model and the checker are compiled first. */
`timescale 1ns/10ps
module tape_record_write_read_sequencer_tb_top;
  import tape_seq_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic run = 1'b0;
  logic ctl_data_request_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [7:0] ctl_write_data_i = 8'h00;
  logic hready_i, hreadyout_o, hresp_o, drive_write_clock_i, drive_read_strobe_i, wclk_q;
  logic drive_write_parity_o, force_channel3_one_o, force_parity_one_o, even, mk;
  logic drive_write_pulse_o, drive_lrc_request_o, ctl_write_ack_o, ctl_read_ack_o;
  logic ctl_crc_error_o, ctl_lrc_error_o, ctl_vparity_error_o, tapemark_found_o;
  logic crc_slot_flag_o, lrc_slot_flag_o;
  logic [31:0] hrdata_o, q;
  logic [8:0] drive_read_data_i, ctl_read_data_o;
  logic [7:0] drive_write_data_o, mask;
  logic [7:0] chars [6];
  int n, ticks, pulses, acks, last_tick, fail_count, checked;
  tape_record_write_read_sequencer u_tape_record_write_read_sequencer
  (
    .clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .drive_write_clock_i,
    .drive_read_strobe_i, .drive_read_data_i, .ctl_data_request_i, .ctl_write_data_i,
    .drive_write_data_o, .drive_write_parity_o, .force_channel3_one_o,
    .force_parity_one_o, .drive_write_pulse_o, .drive_lrc_request_o, .ctl_write_ack_o,
    .ctl_read_data_o, .ctl_read_ack_o, .ctl_crc_error_o, .ctl_lrc_error_o,
    .ctl_vparity_error_o, .tapemark_found_o, .crc_slot_flag_o, .lrc_slot_flag_o
  );
  tape_drive_model u_tape_drive_model
  (
    .run_i(run), .wclk_o(drive_write_clock_i), .strobe_o(drive_read_strobe_i),
    .rdata_o(drive_read_data_i)
  );
  // ****************
  // helpers
  // ****************
  assign hready_i = hreadyout_o;
  always #5 clk_i = ~clk_i;
  // expected lines for a char: zero with even parity becomes a lone bit
  function automatic logic [8:0] fix(input logic [7:0] c, input logic e);
    logic [7:0] d;
    d = (c == 8'h00 && e) ? 8'h04 : c;
    return {(^d) ^ ~e, d};
  endfunction
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i); // one idle edge: launch effects settle, no double drive
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    hsel_i <= 1'b1;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // controller side: count ticks and pulses, hand over the next char per ack
  always @(posedge clk_i)
  begin
    wclk_q <= drive_write_clock_i;
    if (drive_write_clock_i === 1'b1 && wclk_q === 1'b0)
      ticks++;
    if (drive_write_pulse_o === 1'b1)
    begin
      if (pulses < n)
        chk({drive_write_parity_o, drive_write_data_o} === fix(mk ? mask : chars[pulses], even), "char");
      pulses++;
      last_tick = ticks;
    end
    if (ctl_write_ack_o === 1'b1)
    begin
      acks++;
      ctl_write_data_i <= chars[acks];
      ctl_data_request_i <= acks < n - 1;
    end
  end
  task automatic write_op(input logic sev, input logic mark);
    logic [31:0] w;
    mk = mark;
    mask = sev ? 8'h0f : 8'h13;
    even = 1'($urandom) | !(sev | mark);
    n = mark ? 1 : 1 + $urandom % 5;
    for (int i = 0; i < 6; i++)
      chars[i] = i > 0 ? 8'($urandom) : 8'h00;
    w = 32'h111;
    w[CTRL_EVEN_PAR] = even;
    w[CTRL_SEVEN] = sev;
    w[CTRL_TAPEMARK] = mark;
    ctl_write_data_i <= chars[0];
    ctl_data_request_i <= !mark && n > 1;
    ticks = 0;
    pulses = 0;
    acks = 0;
    ahb(1'b1, CTRL_ADDR, w);
    ahb(1'b0, STATUS_ADDR, 32'h0);
    chk(q[ST_WRITE_ACTIVE] === 1'b1, "not writing");
    run <= 1'b1;
    for (int k = 0; k < 900 && pulses < n + 2 - (sev | mark); k++)
      @(posedge clk_i);
    repeat (64) @(posedge clk_i);
    run <= 1'b0;
    chk(pulses == n + 2 - (sev | mark), "pulse count");
    chk(acks == (mark ? 0 : n), "ack count");
    chk(last_tick == n + (sev ? 4 : 8), "lrc place");
    repeat (20) @(posedge clk_i);
  endtask
  task automatic read_op(input logic [7:0] c, input int k, input logic bad);
    ahb(1'b1, CTRL_ADDR, 32'h132);
    run <= 1'b1;
    for (int i = 0; i < k; i++)
    begin
      u_tape_drive_model.send({^c ^ bad, c});
      chk(ctl_read_data_o === {^c ^ bad, c}, "read data");
    end
    repeat (200) @(posedge clk_i);
    chk(tapemark_found_o === (k == 2), "tapemark");
    chk(ctl_vparity_error_o === bad, "parity");
    ahb(1'b0, STATUS_ADDR, 32'h0);
    chk(q[ST_MORE_TWO] === (k > 2), "count");
    chk(q[ST_RECORD] === 1'b1, "record");
    chk({ctl_crc_error_o, ctl_lrc_error_o, crc_slot_flag_o, lrc_slot_flag_o} === {2'b00, k > 2, k == 2}, "slots");
    ahb(1'b1, CTRL_ADDR, 32'h12);
    repeat (2) @(posedge clk_i);
    chk(ctl_read_data_o === ((k % 2) ? {^c ^ bad, c} : 9'h000), "lrc out");
    run <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    void'($urandom(32'hd67bc02e));
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    // read-only and unmapped places ignore writes
    for (int a = 0; a < 16; a += 4)
    begin
      if (a > 0)
        ahb(1'b1, 8'(a), 32'hffff_feff);
      ahb(1'b0, 8'(a), 32'h0);
      chk(q === 32'h0 && hresp_o === 1'b0, "register");
    end
    for (int m = 0; m < 4; m++)
      write_op(m[0], m[1]);
    read_op(8'h13, 2, 1'b0);
    read_op(8'h13, 3, 1'b1);
    read_op(8'($urandom) | 8'h80, 4, 1'b0);
    end_sim();
  end
  // hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    #300000;
    fail_count++;
    end_sim();
  end
endmodule
